// ===== scsdr_eng_if.sv
// Carrier between the register side and the shift engine
`timescale 1ns/10ps
interface scsdr_eng_if;
  import scsdr_pkg::*;
  logic enable, master, clock_polarity, clock_phase, wom;
  scsdr_baud_t baud_sel;
  logic tx_pending, tx_taken, rx_done, ss_rise_busy;
  scsdr_byte_t tx_byte, rx_byte;
  logic sck_in, mosi_in, miso_in, ss_n_in;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  modport ctl (
    output enable, master, clock_polarity, clock_phase, wom, baud_sel, tx_pending, tx_byte,
    output sck_in, mosi_in, miso_in, ss_n_in,
    input tx_taken, rx_done, rx_byte, ss_rise_busy,
    input sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe
  );
  modport eng (
    input enable, master, clock_polarity, clock_phase, wom, baud_sel, tx_pending, tx_byte,
    input sck_in, mosi_in, miso_in, ss_n_in,
    output tx_taken, rx_done, rx_byte, ss_rise_busy,
    output sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe
  );
endinterface : scsdr_eng_if

// ===== scsdr_engine.sv
// Byte shift engine for master and slave operation
`timescale 1ns/10ps
`include "scsdr_params.svh"
module scsdr_engine (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register side
  scsdr_eng_if.eng eng
);
  import scsdr_pkg::*;
  scsdr_state_t state_r;
  scsdr_byte_t sr_r;
  logic [3:0] edge_r;
  logic [7:0] div_r;
  logic [7:0] bd;
  logic sck_r, sck_prev_r, ss_prev_r, in_bit_r;
  logic sck_edge, ss_fall, ss_rise, tick, step, lead, sample, shift, last, start, serial_in;
  logic drive_sck, drive_miso;
  logic [2:0] samp_d_r, last_d_r;
  scsdr_byte_t rx_sh_r;

  // Baud divisor from the select code
  always_comb begin
    case (eng.baud_sel)
      2'b00: bd = `SCSDR_BD0;
      2'b01: bd = `SCSDR_BD1;
      2'b10: bd = `SCSDR_BD2;
      default: bd = `SCSDR_BD3;
    endcase
  end

  // Edge events and sampling roles
  assign sck_edge = eng.sck_in != sck_prev_r;
  assign ss_fall = ss_prev_r && !eng.ss_n_in;
  assign ss_rise = !ss_prev_r && eng.ss_n_in;
  assign tick = eng.master && state_r == SE_RUN && div_r == bd - 8'h01;
  assign step = state_r == SE_RUN && (eng.master ? tick : (sck_edge && !eng.ss_n_in));
  assign lead = !edge_r[0];
  assign sample = eng.clock_phase ? !lead : lead;
  assign shift = eng.clock_phase ? (lead && edge_r != 4'h0) : !lead;
  assign last = edge_r == `SCSDR_LAST_EDGE;
  assign serial_in = eng.master ? eng.miso_in : eng.mosi_in;
  assign start = state_r == SE_IDLE && eng.enable &&
    (eng.master ? eng.tx_pending : (!eng.ss_n_in && (eng.clock_phase ? sck_edge : ss_fall)));
  assign drive_sck = eng.enable && eng.master;
  assign drive_miso = eng.enable && !eng.master && !eng.ss_n_in;

  // Transfer state; disabling the module returns it to idle
  always_ff @(posedge clk_i) begin
    if (rst_i || !eng.enable) begin
      state_r <= SE_IDLE;
      edge_r <= 4'h0;
    end else begin
      case (state_r)
        SE_IDLE: begin
          if (start) begin
            state_r <= SE_RUN;
            edge_r <= (!eng.master && eng.clock_phase) ? 4'h1 : 4'h0;
          end
        end
        SE_RUN: begin
          if (!eng.master && eng.ss_n_in) begin
            state_r <= SE_IDLE;
            edge_r <= 4'h0;
          end else if (step) begin
            edge_r <= edge_r + 4'h1;
            if (last) begin
              state_r <= SE_IDLE;
            end
          end
        end
        default: state_r <= SE_IDLE;
      endcase
    end
  end

  // Master clock divider and serial clock level
  always_ff @(posedge clk_i) begin
    if (rst_i || state_r == SE_IDLE) begin
      div_r <= 8'h00;
      sck_r <= eng.clock_polarity;
    end else if (tick) begin
      div_r <= 8'h00;
      sck_r <= !sck_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // Master input returns three cycles after its own clock edge: pin flop plus two synchroniser flops
  always_ff @(posedge clk_i) begin
    if (rst_i || !eng.enable) begin
      samp_d_r <= 3'h0;
      last_d_r <= 3'h0;
    end else begin
      samp_d_r <= {samp_d_r[1:0], eng.master && step && sample};
      last_d_r <= {last_d_r[1:0], eng.master && step && last};
    end
  end

  // Master receive shifter fed by the delayed sample strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sh_r <= 8'h00;
    end else if (samp_d_r[2]) begin
      rx_sh_r <= {rx_sh_r[6:0], serial_in};
    end
  end

  // Shift register, sampled bit and handshakes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sr_r <= 8'h00;
      in_bit_r <= 1'b0;
      eng.tx_taken <= 1'b0;
      eng.rx_done <= 1'b0;
      eng.rx_byte <= 8'h00;
    end else begin
      eng.tx_taken <= start && eng.tx_pending;
      eng.rx_done <= 1'b0;
      if (start) begin
        sr_r <= eng.tx_byte;
      end else if (step && last) begin
        sr_r <= {sr_r[6:0], eng.clock_phase ? serial_in : in_bit_r};
        if (!eng.master) begin
          eng.rx_byte <= {sr_r[6:0], eng.clock_phase ? serial_in : in_bit_r};
          eng.rx_done <= 1'b1;
        end
      end else if (step && sample) begin
        in_bit_r <= serial_in;
      end else if (step && shift) begin
        sr_r <= {sr_r[6:0], in_bit_r};
      end
      // Master byte completes once its last delayed sample has landed
      if (last_d_r[2]) begin
        eng.rx_byte <= eng.clock_phase ? {rx_sh_r[6:0], serial_in} : rx_sh_r;
        eng.rx_done <= 1'b1;
      end
    end
  end

  // Pin drivers, open drain when wired-OR is selected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_prev_r <= 1'b0;
      ss_prev_r <= 1'b1;
      eng.ss_rise_busy <= 1'b0;
      eng.sck_o <= 1'b0;
      eng.sck_oe <= 1'b0;
      eng.mosi_o <= 1'b0;
      eng.mosi_oe <= 1'b0;
      eng.miso_o <= 1'b0;
      eng.miso_oe <= 1'b0;
    end else begin
      sck_prev_r <= eng.sck_in;
      ss_prev_r <= eng.ss_n_in;
      eng.ss_rise_busy <= !eng.master && state_r == SE_RUN && ss_rise;
      eng.sck_o <= sck_r;
      eng.sck_oe <= drive_sck && (!eng.wom || !sck_r);
      eng.mosi_o <= sr_r[7];
      eng.mosi_oe <= drive_sck && (!eng.wom || !sr_r[7]);
      eng.miso_o <= sr_r[7];
      eng.miso_oe <= drive_miso && (!eng.wom || !sr_r[7]);
    end
  end

  // Serial clock toggles only after a full divisor period
  baud_half_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == SE_RUN && eng.master && sck_r != $past(sck_r) && $past(state_r) == SE_RUN)
    |-> $past(div_r) == $past(bd) - 8'h01)
    else $error("serial clock toggled off the divisor");
  miso_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!eng.master && eng.ss_n_in) |=> !eng.miso_oe)
    else $error("slave drives master-in while deselected");
endmodule : scsdr_engine

// ===== scsdr_params.svh
// Register indices, bit positions, reset values and timing counts of the serial block
`ifndef SCSDR_PARAMS_SVH
`define SCSDR_PARAMS_SVH
`define SCSDR_IDX_CTRL 7'h4c
`define SCSDR_IDX_STAT 7'h4d
`define SCSDR_IDX_DATA 7'h4e
`define SCSDR_C_RXIE 7
`define SCSDR_C_MSTR 5
`define SCSDR_C_CLOCK_POLARITY 4
`define SCSDR_C_CLOCK_PHASE 3
`define SCSDR_C_WOM 2
`define SCSDR_C_EN 1
`define SCSDR_C_TXIE 0
`define SCSDR_CTRL_MASK 8'hbf
`define SCSDR_CTRL_RESET 8'h28
`define SCSDR_S_RXF 7
`define SCSDR_S_ERROR_IRQ_ENABLE 6
`define SCSDR_S_OVR 5
`define SCSDR_S_MODE_FAULT_FLAG 4
`define SCSDR_S_TXE 3
`define SCSDR_S_MFEN 2
`define SCSDR_S_BAUD_HI 1
`define SCSDR_S_BAUD_LO 0
`define SCSDR_BD0 8'd2
`define SCSDR_BD1 8'd8
`define SCSDR_BD2 8'd32
`define SCSDR_BD3 8'd128
`define SCSDR_LAST_EDGE 4'hf
`define SCSDR_SYNC_RESET 4'h8
`endif

// ===== scsdr_partner.sv
// Behavioural far-side slave that answers the block when it runs as master
`timescale 1ns/10ps
module scsdr_partner (
  // Serial pins
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic sel_n_i,
  output logic miso_o,
  // Setup and data
  input wire logic clock_polarity_i,
  input wire logic [7:0] tx_i,
  output logic [7:0] rx_o
);
  logic [7:0] sh = 8'h00;
  int cnt = 0;
  initial miso_o = 1'b0;
  // Phase 1 slave: drive on the leading edge, sample on the trailing edge, MSB first
  always @(sck_i) begin
    if (sel_n_i === 1'b0) begin
      if (sck_i !== clock_polarity_i) begin
        miso_o = tx_i[7 - cnt];
      end else begin
        sh = {sh[6:0], mosi_i};
        cnt = cnt + 1;
        if (cnt == 8) begin
          rx_o = sh;
          cnt = 0;
        end
      end
    end
  end
  // Deselect drops the bit count and inverts the bit left on the line
  always @(posedge sel_n_i) begin
    cnt = 0;
    miso_o = ~miso_o;
  end
endmodule : scsdr_partner

// ===== scsdr_pkg.sv
// Types shared by the serial register block and its shift engine
package scsdr_pkg;
  typedef logic [7:0] scsdr_byte_t;
  typedef logic [1:0] scsdr_baud_t;
  typedef enum logic {SE_IDLE, SE_RUN} scsdr_state_t;
endpackage : scsdr_pkg

// ===== scsdr_regs.sv
// Control, status and data registers of the serial block with Wishbone access
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/10ps
`include "scsdr_params.svh"
module scsdr_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic [8:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  // Serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic ss_n_i,
  // Interrupt request and slave select use
  output logic irq_o,
  output logic ss_in_use_o
);
  import scsdr_pkg::*;

  scsdr_eng_if link ();

  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [7:0] ctrl_r;
  logic error_irq_enable_r, mfen_r;
  scsdr_baud_t baud_r;
  scsdr_byte_t tx_data_r;
  scsdr_byte_t rx_data_r;
  logic tx_empty_r, rx_full_r, ovr_r, mode_fault_flag_r;
  logic rx_arm_r, ovr_arm_r, mode_fault_flag_arm_r;
  logic irq_r, ss_use_r;
  logic [7:0] stat_view;
  logic [6:0] idx;
  logic req, wr, rd, ctrl_wr, stat_wr, data_wr, stat_rd, data_rd;
  logic rx_clr, ovr_clr, mode_fault_flag_clr, mode_fault_flag_set, irq_cond;

  // Pin inputs pass two flops; order is select, master-in, master-out, clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= `SCSDR_SYNC_RESET;
      sync2_r <= `SCSDR_SYNC_RESET;
    end else begin
      sync1_r <= {ss_n_i, miso_i, mosi_i, sck_i};
      sync2_r <= sync1_r;
    end
  end

  // Bus decode; one access per request, acked on the next cycle
  assign idx = adr_i[8:2];
  assign req = cyc_i && stb_i && !ack_r;
  assign wr = req && we_i && sel_i[0];
  assign rd = req && !we_i;
  assign ctrl_wr = wr && idx == `SCSDR_IDX_CTRL;
  assign stat_wr = wr && idx == `SCSDR_IDX_STAT;
  assign data_wr = wr && idx == `SCSDR_IDX_DATA;
  assign stat_rd = rd && idx == `SCSDR_IDX_STAT;
  assign data_rd = rd && idx == `SCSDR_IDX_DATA;

  // Acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // Status view; reserved bits read as zero
  always_comb begin
    stat_view = 8'h00;
    stat_view[`SCSDR_S_RXF] = rx_full_r;
    stat_view[`SCSDR_S_ERROR_IRQ_ENABLE] = error_irq_enable_r;
    stat_view[`SCSDR_S_OVR] = ovr_r;
    stat_view[`SCSDR_S_MODE_FAULT_FLAG] = mode_fault_flag_r;
    stat_view[`SCSDR_S_TXE] = tx_empty_r;
    stat_view[`SCSDR_S_MFEN] = mfen_r;
    stat_view[`SCSDR_S_BAUD_HI] = baud_r[1];
    stat_view[`SCSDR_S_BAUD_LO] = baud_r[0];
  end

  // Read data register; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (rd) begin
      case (idx)
        `SCSDR_IDX_CTRL: dat_r <= {24'h00_0000, ctrl_r};
        `SCSDR_IDX_STAT: dat_r <= {24'h00_0000, stat_view};
        `SCSDR_IDX_DATA: dat_r <= {24'h00_0000, rx_data_r};
        default: dat_r <= 32'h0000_0000;
      endcase
    end
  end

  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `SCSDR_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_r <= dat_i[7:0] & `SCSDR_CTRL_MASK;
    end
  end

  // Writable part of the status and control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      error_irq_enable_r <= 1'b0;
      mfen_r <= 1'b0;
      baud_r <= 2'b00;
    end else if (stat_wr) begin
      error_irq_enable_r <= dat_i[`SCSDR_S_ERROR_IRQ_ENABLE];
      mfen_r <= dat_i[`SCSDR_S_MFEN];
      baud_r <= {dat_i[`SCSDR_S_BAUD_HI], dat_i[`SCSDR_S_BAUD_LO]};
    end
  end

  // Transmit register and its empty flag; a hand-off wins over a write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_empty_r <= 1'b1;
    end else if (!ctrl_r[`SCSDR_C_EN] || link.tx_taken) begin
      tx_empty_r <= 1'b1;
    end else if (data_wr) begin
      tx_empty_r <= 1'b0;
    end
  end

  // Transmit data is not reset
  always_ff @(posedge clk_i) begin
    if (data_wr) begin
      tx_data_r <= dat_i[7:0];
    end
  end

  // Two-step clear conditions
  assign rx_clr = data_rd && rx_arm_r;
  assign ovr_clr = data_rd && ovr_arm_r;
  assign mode_fault_flag_clr = ctrl_wr && mode_fault_flag_arm_r;

  // Receive register; a held byte is never overwritten
  always_ff @(posedge clk_i) begin
    if (link.rx_done && (!rx_full_r || rx_clr)) begin
      rx_data_r <= link.rx_byte;
    end
  end

  // Receive-full flag; a new byte wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_full_r <= 1'b0;
    end else if (link.rx_done) begin
      rx_full_r <= 1'b1;
    end else if (rx_clr) begin
      rx_full_r <= 1'b0;
    end
  end

  // Overflow flag; set wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_r <= 1'b0;
    end else if (link.rx_done && rx_full_r && !rx_clr) begin
      ovr_r <= 1'b1;
    end else if (ovr_clr) begin
      ovr_r <= 1'b0;
    end
  end

  // Mode fault detection; gated by the mode fault enable and the enable bit
  assign mode_fault_flag_set = mfen_r && ctrl_r[`SCSDR_C_EN] &&
    (ctrl_r[`SCSDR_C_MSTR] ? !sync2_r[3] : link.ss_rise_busy);

  // Mode fault flag; set wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_fault_flag_r <= 1'b0;
    end else if (mode_fault_flag_set) begin
      mode_fault_flag_r <= 1'b1;
    end else if (mode_fault_flag_clr) begin
      mode_fault_flag_r <= 1'b0;
    end
  end

  // First step of each clear: status read with the flag set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_arm_r <= 1'b0;
      ovr_arm_r <= 1'b0;
      mode_fault_flag_arm_r <= 1'b0;
    end else begin
      if (rx_clr || !rx_full_r) begin
        rx_arm_r <= 1'b0;
      end else if (stat_rd) begin
        rx_arm_r <= 1'b1;
      end
      if (ovr_clr || !ovr_r) begin
        ovr_arm_r <= 1'b0;
      end else if (stat_rd) begin
        ovr_arm_r <= 1'b1;
      end
      if (mode_fault_flag_clr || !mode_fault_flag_r) begin
        mode_fault_flag_arm_r <= 1'b0;
      end else if (stat_rd) begin
        mode_fault_flag_arm_r <= 1'b1;
      end
    end
  end

  // Interrupt request from enabled flags
  assign irq_cond = (rx_full_r && ctrl_r[`SCSDR_C_RXIE]) ||
    (tx_empty_r && ctrl_r[`SCSDR_C_TXIE]) ||
    ((ovr_r || mode_fault_flag_r) && error_irq_enable_r);

  // Registered interrupt and slave select ownership
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
      ss_use_r <= 1'b0;
    end else begin
      irq_r <= irq_cond;
      ss_use_r <= ctrl_r[`SCSDR_C_EN] && (!ctrl_r[`SCSDR_C_MSTR] || mfen_r);
    end
  end

  // Engine configuration and pins
  assign link.enable = ctrl_r[`SCSDR_C_EN];
  assign link.master = ctrl_r[`SCSDR_C_MSTR];
  assign link.clock_polarity = ctrl_r[`SCSDR_C_CLOCK_POLARITY];
  assign link.clock_phase = ctrl_r[`SCSDR_C_CLOCK_PHASE];
  assign link.wom = ctrl_r[`SCSDR_C_WOM];
  assign link.baud_sel = baud_r;
  assign link.tx_pending = !tx_empty_r;
  assign link.tx_byte = tx_data_r;
  assign link.sck_in = sync2_r[0];
  assign link.mosi_in = sync2_r[1];
  assign link.miso_in = sync2_r[2];
  assign link.ss_n_in = sync2_r[3];

  // Shift engine
  scsdr_engine u_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .eng(link.eng)
  );

  // Outputs
  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign irq_o = irq_r;
  assign ss_in_use_o = ss_use_r;
  assign sck_o = link.sck_o;
  assign sck_oe_o = link.sck_oe;
  assign mosi_o = link.mosi_o;
  assign mosi_oe_o = link.mosi_oe;
  assign miso_o = link.miso_o;
  assign miso_oe_o = link.miso_oe;

  // Reset defaults
  ctrl_reset_a: assert property (@(posedge clk_i)
    rst_i |=> ctrl_r == `SCSDR_CTRL_RESET && tx_empty_r && !rx_full_r && !mode_fault_flag_r)
    else $error("wrong control or flag value after reset");
  rx_irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_full_r && ctrl_r[`SCSDR_C_RXIE]) |=> irq_o)
    else $error("receive-full interrupt not raised");
  irq_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !irq_cond |=> !irq_o)
    else $error("interrupt held without an enabled flag");
  tx_handoff_a: assert property (@(posedge clk_i) disable iff (rst_i)
    link.tx_taken |=> tx_empty_r)
    else $error("transmit-empty not set on hand-off");
  overflow_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (link.rx_done && rx_full_r && !rx_clr) |=> ovr_r && $stable(rx_data_r))
    else $error("overflow lost or held byte overwritten");
  rx_clear_seq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rx_full_r) |-> $past(rx_arm_r) && $past(data_rd))
    else $error("receive-full cleared without the read sequence");
  mode_fault_flag_clear_seq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(mode_fault_flag_r) |-> $past(mode_fault_flag_arm_r) && $past(ctrl_wr))
    else $error("mode fault cleared without the sequence");
  mode_fault_flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_fault_flag_r && !mode_fault_flag_clr) |=> mode_fault_flag_r)
    else $error("mode fault dropped without a clear");
  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("bus answer not a one-cycle ack");
endmodule : scsdr_regs

// ===== scsdr_regs_bench.sv
// Self-checking bench for the serial register block
`timescale 1ns/10ps
module scsdr_regs_bench;
  import scsdr_pkg::*;
  localparam logic [8:0] CTL = 9'h130;
  localparam logic [8:0] STA = 9'h134;
  localparam logic [8:0] DAT = 9'h138;
  // Stimulus, observed outputs and result notes
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [8:0] adr_i = 9'h000;
  logic [31:0] dat_i = 32'h0;
  logic [3:0] sel_i = 4'h0;
  logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, ss_n_i = 1'b1, psel_n = 1'b1;
  logic [31:0] dat_o;
  logic ack_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, irq_o, ss_in_use_o;
  logic sck_w, mosi_w, miso_w, sck_prev;
  logic wom_on = 1'b0;
  scsdr_byte_t ptx = 8'h00, prx, rd_v, tv, v;
  int seed = 72;
  int err_total = 0;
  int check_count = 0;
  int tick = 0;
  int half = 0;
  scsdr_byte_t exp_q[$], msk_q[$];
  string nm_q[$];
  // Released open-drain lines float high through the pull-up
  assign sck_w = sck_oe_o ? sck_o : 1'b1;
  assign mosi_w = mosi_oe_o ? mosi_o : 1'b1;
  always #50 clk_i = ~clk_i;
  scsdr_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
    .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .sck_i(sck_w), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_w),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o), .ss_n_i(ss_n_i), .irq_o(irq_o), .ss_in_use_o(ss_in_use_o));
  scsdr_partner part_u (.sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(psel_n), .miso_o(miso_w), .clock_polarity_i(1'b0),
    .tx_i(ptx), .rx_o(prx));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // Watcher: serial clock half period, open drain clock, read data against the oldest note
  always @(negedge clk_i) begin
    tick = tick + 1;
    if (sck_o !== sck_prev) begin
      half = tick;
      tick = 0;
      sck_prev = sck_o;
    end
    if (wom_on && sck_oe_o === 1'b1 && sck_o === 1'b1) check("sck open drain", 8'h1, 8'h0);
    if (ack_o === 1'b1 && we_i === 1'b0 && nm_q.size() > 0) begin
      check(nm_q.pop_front(), dat_o[7:0] & msk_q[0], exp_q.pop_front() & msk_q[0]);
      msk_q.delete(0);
    end
  end
  // One classic Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [8:0] a, input scsdr_byte_t d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    sel_i <= 4'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      close_out();
    end
    rd_v = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [8:0] a, input scsdr_byte_t d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [8:0] a, input scsdr_byte_t e, input scsdr_byte_t m, input string nm);
    nm_q.push_back(nm);
    exp_q.push_back(e);
    msk_q.push_back(m);
    wb(1'b0, a, 8'h00);
  endtask : rd
  // Send one byte as master and poll status until the given bit rises
  task automatic xfer(input scsdr_byte_t t, input scsdr_byte_t p, input int b);
    int n;
    n = 0;
    ptx <= p;
    wr(DAT, t);
    do begin
      rd(STA, 8'h00, 8'h00, "poll");
      n++;
    end while (rd_v[b] !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      err_total++;
      close_out();
    end
  endtask : xfer
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CTL, 8'h28, 8'hff, "control reset");
    rd(STA, 8'h08, 8'hff, "status reset");
    wr(9'h1f0, 8'hff);
    rd(9'h1f0, 8'h00, 8'hff, "unmapped");
    v = 8'($random(seed)) & 8'hbd;
    wr(CTL, v);
    rd(CTL, v, 8'hff, "control readback");
    wr(CTL, 8'h3a);
    repeat (4) @(posedge clk_i);
    check("sck idle level", sck_o, 1'b1);
    wr(CTL, 8'h29);
    repeat (3) @(posedge clk_i);
    check("tx irq", irq_o, 1'b1);
    wr(CTL, 8'h28);
    repeat (3) @(posedge clk_i);
    check("tx irq off", irq_o, 1'b0);
    for (int c = 0; c < 4; c++) begin
      wom_on = (c == 0);
      wr(STA, 8'(c));
      wr(CTL, c == 0 ? 8'hae : 8'haa);
      repeat (2) @(posedge clk_i);
      psel_n <= 1'b0;
      tv = 8'($random(seed));
      v = 8'($random(seed));
      xfer(tv, v, 7);
      check("rx irq", irq_o, 1'b1);
      rd(STA, 8'h88 | 8'(c), 8'hff, "status full");
      rd(DAT, v, 8'hff, "rx data");
      check("partner rx", prx, tv);
      check("sck half period", 8'(half), 8'(2 << (2 * c)));
      rd(STA, 8'h08 | 8'(c), 8'hff, "status cleared");
      check("irq cleared", irq_o, 1'b0);
      psel_n <= 1'b1;
    end
    wom_on = 1'b0;
    wr(STA, 8'h40);
    wr(CTL, 8'h2a);
    psel_n <= 1'b0;
    tv = 8'($random(seed));
    v = 8'($random(seed));
    xfer(tv, v, 7);
    xfer(8'h5a, 8'ha5, 5);
    check("error irq", irq_o, 1'b1);
    rd(STA, 8'he8, 8'hff, "status overflow");
    rd(DAT, v, 8'hff, "kept byte");
    rd(STA, 8'h48, 8'hff, "overflow cleared");
    psel_n <= 1'b1;
    wr(STA, 8'h04);
    ss_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    check("select in use", ss_in_use_o, 1'b1);
    ss_n_i <= 1'b1;
    rd(STA, 8'h1c, 8'hff, "mode fault");
    wr(STA, 8'h00);
    @(posedge clk_i);
    check("select free", ss_in_use_o, 1'b0);
    rd(STA, 8'h18, 8'hff, "fault kept");
    wr(CTL, 8'h2a);
    rd(STA, 8'h08, 8'hff, "fault cleared");
    ss_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(STA, 8'h08, 8'hff, "select ignored");
    ss_n_i <= 1'b1;
    wr(CTL, 8'h0a);
    ss_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("slave miso drive", miso_oe_o, 1'b1);
    check("slave select use", ss_in_use_o, 1'b1);
    check("slave sck input", sck_oe_o, 1'b0);
    ss_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check("slave miso release", miso_oe_o, 1'b0);
    wr(CTL, 8'h28);
    close_out();
  end
endmodule : scsdr_regs_bench
